//--- include/dip_pkg.sv
package dip_pkg;
    // Slot and channel geometry
    localparam int DIP_NSLOT = 4;
    localparam int DIP_CH_W = 16;
    localparam int DIP_IMG_W = 128;
    localparam int DIP_IMG_WORDS = 4;
    localparam logic [2:0] DIP_MAX_ANA_WORDS = 3'h4;
    // Register byte offsets
    localparam logic [7:0] DIP_OFS_CTRL = 8'h00;
    localparam logic [7:0] DIP_OFS_ACK = 8'h04;
    localparam logic [7:0] DIP_OFS_INFO = 8'h08;
    localparam logic [7:0] DIP_OFS_IMG0 = 8'h10;
    // Control field positions: slot kind i at [4i+2:4i], analog words at [18:16]
    localparam int DIP_CTRL_KIND_POS = 0;
    localparam int DIP_CTRL_KIND_STRIDE = 4;
    localparam int DIP_CTRL_ANA_POS = 16;
    // Acknowledge byte per slot: ack channel 1 and 2 at bits 2 and 3
    localparam int DIP_ACK_STRIDE = 8;
    localparam int DIP_ACK_POS = 2;
    // Info field positions
    localparam int DIP_INFO_BITS_POS = 0;
    localparam int DIP_INFO_SUB_POS = 8;
    localparam int DIP_INFO_IN_POS = 16;
    localparam int DIP_INFO_OUT_POS = 24;
    // Object class codes; info holds instance counts of them, not the codes
    localparam logic [7:0] DIP_CLASS_IN = 8'h65;
    localparam logic [7:0] DIP_CLASS_OUT = 8'h66;
    // Reset values
    localparam logic [31:0] DIP_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] DIP_ACK_RST = 32'h0000_0000;
    // AXI responses
    localparam logic [1:0] DIP_RESP_OKAY = 2'h0;
    localparam logic [1:0] DIP_RESP_SLVERR = 2'h2;
    // Module kinds placed in a slot
    typedef enum logic [2:0] {
        DIP_K_NONE = 3'h0,
        DIP_K_DI1_DIAG = 3'h1,
        DIP_K_DI2 = 3'h2,
        DIP_K_DI2_DIAG = 3'h3,
        DIP_K_DI2_ACK = 3'h4,
        DIP_K_DI4 = 3'h5,
        DIP_K_DI8 = 3'h6,
        DIP_K_DI16 = 3'h7
    } dip_kind_t;
endpackage : dip_pkg

//--- logic/dip_packer.sv
`timescale 1ns/10ps
// Overview of operation
// - One image bit per channel, its state
// - Digital bits follow analog data, bit packed
// - One sub-index per eight digital bits
// - Each input image bit takes one 0x65 instance
// - Position counts data of earlier slots
// - One-channel diag: data bit0, diag bit1
// - Two-channel: channel1 bit0, channel2 bit1
// - Two-channel diag: data 0-1, diag 2-3
// - Diag bit set on channel fault
// - Ack module sets diag on any fault
// - Input stays off until acknowledged after fault
// - Ack bits at 2-3, bits 0-1 zero
// - Ack module adds four 0x66 instances
// - Four channels on bits 0-3 ascending
// - Eight channels on bits 0-7 ascending
// - Sixteen channels on bits 0-15 ascending
// - Word aligned, little-endian image
module dip_packer
    import dip_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    // Field side: 16 channel levels and 2 fault levels per slot
    input wire logic [DIP_NSLOT*DIP_CH_W-1:0] field_in,
    input wire logic [DIP_NSLOT*2-1:0] field_fault,
    // Process image cycle pulse
    input wire logic cycle_strobe,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // Image bits a slot kind occupies, also its input instance count
    function automatic logic [4:0] kind_width(input logic [2:0] k);
        // Kind code decides how many image bits the slot takes
        case (dip_kind_t'(k))
            DIP_K_DI1_DIAG: kind_width = 5'h02;
            DIP_K_DI2: kind_width = 5'h02;
            DIP_K_DI2_DIAG: kind_width = 5'h04;
            DIP_K_DI2_ACK: kind_width = 5'h04;
            DIP_K_DI4: kind_width = 5'h04;
            DIP_K_DI8: kind_width = 5'h08;
            DIP_K_DI16: kind_width = 5'h10;
            default: kind_width = 5'h00;
        endcase
    endfunction : kind_width

    // Bit pattern of one slot; bits beyond the layout stay zero
    function automatic logic [15:0] kind_pattern(
        input logic [2:0] k,
        input logic [15:0] d,
        input logic [1:0] flt,
        input logic [1:0] lck
    );
        kind_pattern = 16'h0000;
        // Each layout starts at bit 0 of its slot
        case (dip_kind_t'(k))
            DIP_K_DI1_DIAG: kind_pattern = {14'h0000, flt[0], d[0]};
            DIP_K_DI2: kind_pattern = {14'h0000, d[1:0]};
            DIP_K_DI2_DIAG: kind_pattern = {12'h000, flt, d[1:0]};
            DIP_K_DI2_ACK: kind_pattern = {12'h000, lck, d[1:0] & ~lck};
            DIP_K_DI4: kind_pattern = {12'h000, d[3:0]};
            DIP_K_DI8: kind_pattern = {8'h00, d[7:0]};
            DIP_K_DI16: kind_pattern = d;
            default: kind_pattern = 16'h0000;
        endcase
    endfunction : kind_pattern

    // Register state
    logic [31:0] ctrl_q; // Slot kinds and analog length
    logic [31:0] ctrl_d;
    logic [31:0] ack_q; // Output image acknowledge bytes
    logic [31:0] ack_d;
    logic [DIP_NSLOT*2-1:0] lock_q; // Channel held off after fault
    logic [DIP_NSLOT*2-1:0] lock_d;
    logic [DIP_IMG_W-1:0] img_q; // Snapshot of input image
    logic [DIP_IMG_W-1:0] img_d;
    // Write response registers
    logic bvalid_q;
    logic bvalid_d;
    logic [1:0] bresp_q;
    logic [1:0] bresp_d;
    // Read response registers
    logic rvalid_q;
    logic rvalid_d;
    logic [1:0] rresp_q;
    logic [1:0] rresp_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    // Combinational image and counts
    logic [DIP_IMG_W-1:0] img_live; // Image built from current inputs
    logic [6:0] dig_bits; // Digital bits in use
    logic [7:0] sub_cnt; // Sub-index count
    logic [7:0] in_inst; // Input point instances
    logic [7:0] out_inst; // Output point instances
    logic [31:0] info_word;
    // Take strobes of the two request channels
    logic wr_go;
    logic rd_go;

    // Image assembly: walk slots, pack each behind the ones before
    always_comb begin
        logic [6:0] pos;
        logic [2:0] ana;
        logic [2:0] k;
        pos = 7'h00;
        ana = 3'h0;
        k = 3'h0;
        img_live = '0;
        dig_bits = 7'h00;
        in_inst = 8'h00;
        out_inst = 8'h00;
        ana = ctrl_q[DIP_CTRL_ANA_POS +: 3];
        // Analog area is whole words, so digital data starts aligned
        if (ana > DIP_MAX_ANA_WORDS) begin
            ana = DIP_MAX_ANA_WORDS;
        end
        pos = {ana, 4'h0};
        for (int i = 0; i < DIP_NSLOT; i++) begin
            // Slot kind for this pass of the walk
            k = ctrl_q[i*DIP_CTRL_KIND_STRIDE + DIP_CTRL_KIND_POS +: 3];
            img_live = img_live | ({{(DIP_IMG_W-16){1'b0}},
                kind_pattern(k, field_in[i*DIP_CH_W +: DIP_CH_W],
                    field_fault[i*2 +: 2], lock_q[i*2 +: 2])} << pos);
            pos = pos + 7'(kind_width(k));
            dig_bits = dig_bits + 7'(kind_width(k));
            in_inst = in_inst + 8'(kind_width(k));
            if (dip_kind_t'(k) == DIP_K_DI2_ACK) begin
                out_inst = out_inst + 8'h04;
            end
        end
        sub_cnt = 8'((8'(dig_bits) + 8'h07) >> 3);
    end

    // Info word shown to software
    always_comb begin
        // Counts come from the same slot walk as the image
        info_word = '0;
        info_word[DIP_INFO_BITS_POS +: 8] = 8'(dig_bits);
        info_word[DIP_INFO_SUB_POS +: 8] = sub_cnt;
        info_word[DIP_INFO_IN_POS +: 8] = in_inst;
        info_word[DIP_INFO_OUT_POS +: 8] = out_inst;
    end

    // Fault latch: a fault locks the channel, ack releases it once clear
    always_comb begin
        logic [1:0] ackb;
        lock_d = lock_q;
        ackb = 2'h0;
        for (int i = 0; i < DIP_NSLOT; i++) begin
            ackb = ack_q[i*DIP_ACK_STRIDE + DIP_ACK_POS +: 2];
            if (dip_kind_t'(ctrl_q[i*DIP_CTRL_KIND_STRIDE +: 3]) == DIP_K_DI2_ACK) begin
                // Fault sets and wins over a simultaneous acknowledge
                lock_d[i*2 +: 2] = field_fault[i*2 +: 2]
                    | (lock_q[i*2 +: 2] & ~ackb);
            end else begin
                // Slots without acknowledge drop any lock at the next clock
                lock_d[i*2 +: 2] = 2'h0;
            end
        end
    end

    // Snapshot register: whole image changes only at the cycle pulse
    always_comb begin
        // Between pulses the image holds still
        img_d = img_q;
        if (cycle_strobe) begin
            img_d = img_live;
        end
    end

    // Bus handshakes: write takes address and data together
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
    assign rd_go = s_axi_arvalid && !rvalid_q;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_arready = rd_go;
    // Responses come straight from their registers
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    // Register writes and write response
    always_comb begin
        ctrl_d = ctrl_q;
        ack_d = ack_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        // Response leaves once the master takes it
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (wr_go) begin
            bvalid_d = 1'b1;
            bresp_d = DIP_RESP_OKAY;
            case ({s_axi_awaddr[7:2], 2'h0})
                DIP_OFS_CTRL: begin
                    for (int b = 0; b < 4; b++) begin
                        if (s_axi_wstrb[b]) begin
                            ctrl_d[b*8 +: 8] = s_axi_wdata[b*8 +: 8];
                        end
                    end
                end
                DIP_OFS_ACK: begin
                    for (int b = 0; b < 4; b++) begin
                        if (s_axi_wstrb[b]) begin
                            ack_d[b*8 +: 8] = s_axi_wdata[b*8 +: 8];
                        end
                    end
                end
                default: bresp_d = DIP_RESP_SLVERR; // Read-only or unmapped
            endcase
            // Only ack bits 2 and 3 of each byte exist; bits 0,1 stay zero
            for (int i = 0; i < DIP_NSLOT; i++) begin
                ack_d[i*DIP_ACK_STRIDE +: 8] =
                    ack_d[i*DIP_ACK_STRIDE +: 8] & 8'h0c;
            end
        end
    end

    // Register reads and read response
    always_comb begin
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        // Response leaves once the master takes it
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (rd_go) begin
            rvalid_d = 1'b1;
            rresp_d = DIP_RESP_OKAY;
            rdata_d = 32'h0000_0000;
            case ({s_axi_araddr[7:2], 2'h0})
                DIP_OFS_CTRL: rdata_d = ctrl_q;
                DIP_OFS_ACK: rdata_d = ack_q;
                DIP_OFS_INFO: rdata_d = info_word;
                default: begin
                    if (s_axi_araddr[7:4] == DIP_OFS_IMG0[7:4]) begin
                        // Byte n of the image sits at bits 8n: little-endian
                        rdata_d = img_q[s_axi_araddr[3:2]*32 +: 32];
                    end else begin
                        // Unmapped read: zero data with an error
                        rresp_d = DIP_RESP_SLVERR;
                    end
                end
            endcase
        end
    end

    // State registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // Synchronous reset: every register to its reset value
            ctrl_q <= DIP_CTRL_RST;
            ack_q <= DIP_ACK_RST;
            lock_q <= '0;
            img_q <= '0;
            bvalid_q <= 1'b0;
            bresp_q <= DIP_RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q <= DIP_RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end else begin
            // Normal running: take the next values
            ctrl_q <= ctrl_d;
            ack_q <= ack_d;
            lock_q <= lock_d;
            img_q <= img_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
        end
    end

endmodule : dip_packer

//--- test/dip_consumer.sv
`timescale 1ns/10ps
// Consumer model: holds acknowledge levels for slot 0
module dip_consumer (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [1:0] ack_set,
    output logic [31:0] ack_word
);
    logic [1:0] ack_q; // Held levels
    logic [1:0] ack_d; // Next levels
    // Keep the level software asks for
    always_comb begin
        ack_d = ack_set;
    end
    // Register the levels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ack_q <= 2'h0;
        end else begin
            ack_q <= ack_d;
        end
    end
    // Ack bits at 2 and 3, low bits zero
    assign ack_word = {28'h0, ack_q, 2'h0};
endmodule : dip_consumer

//--- test/dip_packer_assertions.sv
`timescale 1ns/10ps
// Bus handshake checks on the packer ports
module dip_packer_assertions
    import dip_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_aw_take: assert property (s_axi_awready == (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid))
        else $error("awready wrong");
    a_w_take: assert property (s_axi_wready == (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid))
        else $error("wready wrong");
    a_ar_take: assert property (s_axi_arready == (s_axi_arvalid && !s_axi_rvalid))
        else $error("arready wrong");
    a_b_answer: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid)
        else $error("no write answer");
    a_r_answer: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
        else $error("no read answer");
    a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("bvalid held");
    a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("rvalid held");
    c_wr: cover property (s_axi_bvalid && s_axi_bready);
    c_rd: cover property (s_axi_rvalid && s_axi_rready);
    c_err: cover property (s_axi_rvalid && s_axi_rresp == DIP_RESP_SLVERR);
endmodule : dip_packer_assertions
bind dip_packer dip_packer_assertions dip_packer_assertions_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp));

//--- test/tb_digital_input_image_packer.sv
`timescale 1ns/10ps
module tb_digital_input_image_packer;
    import dip_pkg::*;
    logic aclk = 0, aresetn = 0, cs = 0, awv = 0, wv = 0, bv, brd = 0, arv = 0, rv, rrd = 0;
    logic awr, wr_rdy, arr;
    logic [63:0] fin = '0;
    logic [7:0] flt = '0, awa = '0, ara = '0;
    logic [31:0] wd = '0, rd, ackw, rs = 32'h5c25a138;
    logic [1:0] br, rr, ack_set = '0;
    logic [3:0] ws = 4'hf;
    int n_errors = 0, checks = 0;
    always #2 aclk = ~aclk;
    dip_packer dip_packer_inst (.aclk(aclk), .aresetn(aresetn), .field_in(fin),
        .field_fault(flt), .cycle_strobe(cs), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wr_rdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brd),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrd));
    dip_consumer dip_consumer_inst (.aclk(aclk), .aresetn(aresetn), .ack_set(ack_set),
        .ack_word(ackw));
    task automatic stop_test();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : stop_test
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic chk_resp(input string s, input logic [1:0] e, input logic [1:0] g);
        chk(s, {30'h0, e}, {30'h0, g});
    endtask : chk_resp
    // Bus write: address and data together, wait for answer
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        brd <= 1'b1;
        do @(posedge aclk); while (awr !== 1'b1);
        awv <= 1'b0;
        wv <= 1'b0;
        while (bv !== 1'b1) @(posedge aclk);
        r = br;
        brd <= 1'b0;
    endtask : bus_wr
    // Bus read: hold request until taken, then wait for data
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        ara <= a;
        arv <= 1'b1;
        rrd <= 1'b1;
        do @(posedge aclk); while (arr !== 1'b1);
        arv <= 1'b0;
        while (rv !== 1'b1) @(posedge aclk);
        d = rd;
        r = rr;
        rrd <= 1'b0;
    endtask : bus_rd
    task automatic pulse();
        @(posedge aclk);
        cs <= 1'b1;
        @(posedge aclk);
        cs <= 1'b0;
    endtask : pulse
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // Expected image and info word for a control setting and field levels
    function automatic logic [127:0] exp_img(input logic [31:0] c, input logic [63:0] d,
        input logic [7:0] f, output logic [31:0] inf);
        logic [127:0] m;
        logic [15:0] u, v;
        logic [1:0] g;
        int p, b, o;
        m = '0;
        b = 0;
        o = 0;
        p = (c[18:16] > 3'h4 ? 4 : int'(c[18:16])) * 16;
        for (int i = 0; i < 4; i++) begin
            v = d[16*i +: 16];
            g = f[2*i +: 2];
            case (c[4*i +: 3])
                3'h1: u = {14'h0, g[0], v[0]};
                3'h2, 3'h4: u = {14'h0, v[1:0]};
                3'h3: u = {12'h0, g, v[1:0]};
                3'h5: u = {12'h0, v[3:0]};
                3'h6: u = {8'h0, v[7:0]};
                3'h7: u = v;
                default: u = 16'h0;
            endcase
            m = m | (128'(u) << p);
            case (c[4*i +: 3])
                3'h0: p = p;
                3'h1, 3'h2: b += 2;
                3'h6: b += 8;
                3'h7: b += 16;
                default: b += 4;
            endcase
            o += (c[4*i +: 3] == 3'h4) ? 4 : 0;
            p = (c[18:16] > 3'h4 ? 4 : int'(c[18:16])) * 16 + b;
        end
        inf = {8'(o), 8'(b), 8'((b + 7) / 8), 8'(b)};
        return m;
    endfunction : exp_img
    task automatic img_check(input logic [127:0] e);
        logic [31:0] g;
        logic [1:0] r;
        for (int k = 0; k < 4; k++) begin
            bus_rd(DIP_OFS_IMG0 + 8'(4 * k), g, r);
            chk("image word", e[32*k +: 32], g);
        end
    endtask : img_check
    initial begin
        #200000;
        n_errors++;
        stop_test();
    end
    initial begin
        logic [31:0] c, g, inf;
        logic [1:0] r;
        logic [127:0] e;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        bus_rd(DIP_OFS_CTRL, g, r);
        chk("ctrl reset", DIP_CTRL_RST, g);
        bus_rd(8'h40, g, r);
        chk_resp("unmapped read", DIP_RESP_SLVERR, r);
        bus_wr(DIP_OFS_INFO, 32'h1, r);
        chk_resp("info write", DIP_RESP_SLVERR, r);
        bus_wr(DIP_OFS_ACK, 32'hffff_ffff, r);
        bus_rd(DIP_OFS_ACK, g, r);
        chk("ack bits", 32'h0c0c_0c0c, g);
        bus_wr(DIP_OFS_ACK, 32'h0, r);
        // Byte strobes: only the lowest control byte may change
        ws <= 4'h1;
        bus_wr(DIP_OFS_CTRL, 32'hffff_ffff, r);
        ws <= 4'hf;
        bus_rd(DIP_OFS_CTRL, g, r);
        chk("ctrl strobe", 32'h0000_00ff, g);
        // Random layouts, slot 0 walks every kind; ack slots kept fault free
        for (int t = 0; t < 24; t++) begin
            rs = lfsr(rs);
            c = (rs & 32'h0007_7770) | 32'(t % 8);
            rs = lfsr(rs);
            g = lfsr(rs);
            for (int i = 0; i < 4; i++) if (c[4*i +: 3] == 3'h4) g[2*i +: 2] = 2'h0;
            // Faults settle before the new layout, so no ack slot locks
            fin <= {rs, ~rs};
            flt <= g[7:0];
            bus_wr(DIP_OFS_CTRL, c, r);
            e = exp_img(c, {rs, ~rs}, g[7:0], inf);
            pulse();
            img_check(e);
            bus_rd(DIP_OFS_INFO, g, r);
            chk("info", inf, g);
        end
        // Fault on an ack slot: locked until acknowledged
        flt <= 8'h0;
        bus_wr(DIP_OFS_CTRL, 32'h4, r);
        fin <= 64'h3;
        flt <= 8'h1;
        pulse();
        img_check(128'h6);
        flt <= 8'h0;
        pulse();
        img_check(128'h6);
        ack_set <= 2'h1;
        repeat (2) @(posedge aclk);
        bus_wr(DIP_OFS_ACK, ackw, r);
        pulse();
        img_check(128'h3);
        ack_set <= 2'h0;
        bus_wr(DIP_OFS_ACK, 32'h0, r);
        stop_test();
    end
endmodule : tb_digital_input_image_packer
